// ===== rtl/bridge_err_pkg.sv
// constants, field positions and types shared by the bridge error handler
package bridge_err_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] CTL_ADDR   = 32'h2008_0000;
  localparam logic [31:0] FLAG_ADDR  = 32'h2008_0004;
  localparam logic [31:0] BPERR_ADDR = 32'h2008_0008;
  localparam logic [31:0] DMAE_ADDR  = 32'h2008_000C;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          FLAG_MTO    = 7;   // master timeout
  localparam int          FLAG_PAR    = 5;   // remote parity error
  localparam int          FLAG_MEM    = 4;   // main memory error
  localparam int          FLAG_LOST   = 3;   // lost error address
  localparam int          FLAG_NOGNT  = 2;   // no grant timeout
  localparam int          FLAG_DNEM   = 0;   // dma non-existent memory
  localparam logic [7:0]  FLAG_IMPL   = 8'hBD;
  localparam logic [7:0]  FLAG_RESET  = 8'h00;
  localparam int          CTL_PWR     = 15;
  localparam int          DMAE_LO     = 9;   // mapped address bits 28:9
  localparam int          DMAE_HI     = 28;
  localparam int          BPERR_LO    = 9;   // backplane address bits 21:9
  localparam int          BPERR_HI    = 21;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ          = 40000;
  localparam int unsigned NEM_TIME_NS      = 10000;
  localparam int unsigned ACK_TIME_NS      = 10000;
  localparam int unsigned NOGRANT_TIME_US  = 10000;
  localparam int unsigned SETTLE_TIME_NS   = 500;
  localparam int unsigned NEM_CYCLES       = NEM_TIME_NS * CLK_KHZ / 1000000;
  localparam int unsigned ACK_CYCLES       = ACK_TIME_NS * CLK_KHZ / 1000000;
  localparam int unsigned NOGRANT_CYCLES   = NOGRANT_TIME_US * CLK_KHZ / 1000;
  localparam int unsigned SETTLE_CYCLES    = (SETTLE_TIME_NS * CLK_KHZ + 999999) / 1000000;

  // ----------------------------------------------------------------
  // trap encodings
  // ----------------------------------------------------------------
  localparam logic [4:0]  LVL_WRITE_NEM    = 5'h1D;
  localparam logic [7:0]  VEC_WRITE_NEM    = 8'h60;
  localparam logic [7:0]  VEC_POWERFAIL    = 8'h0C;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {KIND_DEMAND = 2'h0, KIND_PREFETCH = 2'h1, KIND_INTACK = 2'h2} ref_kind_e;
  typedef enum logic [1:0] {SIZE_BYTE = 2'h0, SIZE_HALF = 2'h1, SIZE_WORD = 2'h2} acc_size_e;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_GRANT = 3'b010, ST_REPLY = 3'b100} ref_state_e;
  typedef enum logic [2:0] {AR_IDLE = 3'b001, AR_GRANT = 3'b010, AR_SETTLE = 3'b100} arb_state_e;

endpackage : bridge_err_pkg

// ===== rtl/bridge_err_if.sv
// carriers between the error handler and its timers and access checker
`timescale 1ns/1ps

interface timer_if;
  logic run;
  logic expired;
  modport owner (output run, input expired);
  modport timer (input run, output expired);
endinterface : timer_if

interface check_if;
  import bridge_err_pkg::*;
  logic [1:0]  ref_size;
  logic [31:0] reg_addr;
  logic        ref_legal;
  logic [3:0]  reg_hit;   // ctl, flag, bperr, dmae
  modport owner (output ref_size, output reg_addr, input ref_legal, input reg_hit);
  modport check (input ref_size, input reg_addr, output ref_legal, output reg_hit);
endinterface : check_if

// ===== rtl/timeout_timer.sv
// run-while-high timeout counter; expiry stays high until run drops
`timescale 1ns/1ps

module timeout_timer
  import bridge_err_pkg::*;
#(
  parameter int unsigned LIMIT = 400
)(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // owner side
  timer_if.timer   t
);

  localparam int W = $clog2(LIMIT + 1);
  logic [W-1:0] cnt;

  // counter saturates at LIMIT-1 so expired holds high until run drops, never pulsing again
  always_ff @(posedge clock)
  begin
    if (rst || !t.run)
      cnt <= '0;
    else if (cnt != W'(LIMIT - 1))
      cnt <= cnt + W'(1);
  end

  // fires on the LIMIT-th cycle of run
  assign t.expired = t.run && (cnt == W'(LIMIT - 1));

endmodule : timeout_timer

// ===== rtl/access_checker.sv
// reference size check and register address decode
`timescale 1ns/1ps

module access_checker
  import bridge_err_pkg::*;
(
  check_if.check c
);

  // masked and unmasked words both arrive as word size; mask is not inspected
  assign c.ref_legal  = (c.ref_size == SIZE_WORD);
  assign c.reg_hit[0] = (c.reg_addr == CTL_ADDR);
  assign c.reg_hit[1] = (c.reg_addr == FLAG_ADDR);
  assign c.reg_hit[2] = (c.reg_addr == BPERR_ADDR);
  assign c.reg_hit[3] = (c.reg_addr == DMAE_ADDR);

endmodule : access_checker

// ===== rtl/backplane_bridge_error_handler.sv
// error detection, timing and reporting of the cpu-to-backplane bridge
`timescale 1ns/1ps

module backplane_bridge_error_handler
  import bridge_err_pkg::*;
#(
  parameter int unsigned NO_GRANT_CYCLES = NOGRANT_CYCLES
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire logic        reg_strobe,
  input  wire logic        reg_write,
  input  wire logic [31:0] reg_addr,
  input  wire logic [1:0]  reg_size,
  input  wire logic [3:0]  reg_byte_en,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  // cpu reference to backplane space
  input  wire logic        ref_start,
  input  wire logic        ref_write,
  input  wire logic [1:0]  ref_kind,
  input  wire logic [1:0]  ref_size,
  input  wire logic [21:0] ref_addr,
  output logic             ref_done,
  output logic             ref_abort,
  output logic             cache_invalidate,
  // backplane mastership and reply
  output logic             bp_request,
  input  wire logic        bp_granted,
  input  wire logic        bp_reply,
  input  wire logic [1:0]  remote_parity_lines,
  // dma side
  input  wire logic        dma_bus_req,
  input  wire logic        dma_ack,
  output logic             dma_grant,
  input  wire logic        mem_error,
  input  wire logic        dma_nem_error,
  input  wire logic [28:0] dma_map_addr,
  // power and housekeeping
  input  wire logic        power_good_line,
  input  wire logic        dc_good_line,
  input  wire logic        cpu_halted,
  input  wire logic        io_reset,
  // error reporting
  output logic             machine_check,
  output logic             bus_exception,
  output logic             host_error_interrupt,
  output logic             dp_interrupt,
  output logic      [7:0]  dp_vector,
  output logic      [4:0]  interrupt_priority_level
);

  // ----------------------------------------------------------------
  // helpers: timers and access checker
  // ----------------------------------------------------------------
  timer_if grant_t ();
  timer_if reply_t ();
  timer_if ack_t ();
  timer_if settle_t ();
  check_if chk ();

  timeout_timer #(.LIMIT(NO_GRANT_CYCLES)) u_grant_timer (.clock(clock), .rst(rst), .t(grant_t));
  timeout_timer #(.LIMIT(NEM_CYCLES))      u_reply_timer (.clock(clock), .rst(rst), .t(reply_t));
  timeout_timer #(.LIMIT(ACK_CYCLES))      u_ack_timer   (.clock(clock), .rst(rst), .t(ack_t));
  timeout_timer #(.LIMIT(SETTLE_CYCLES))   u_settle_timer(.clock(clock), .rst(rst), .t(settle_t));
  access_checker u_check (.c(chk));

  assign chk.ref_size = ref_size;
  assign chk.reg_addr = reg_addr;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ref_state_e  st;
  ref_state_e  next_st;
  arb_state_e  ar;
  arb_state_e  next_ar;
  logic        k_write;
  logic [1:0]  k_kind;
  logic [12:0] k_page;
  logic [7:0]  flag;
  logic [19:0] dmae;
  logic [12:0] bperr;
  logic        pg_q;

  // the local cpu bus carries no parity, so nothing here checks or makes it

  // ----------------------------------------------------------------
  // cpu reference sequencing
  // ----------------------------------------------------------------
  wire take       = ref_start && (st == ST_IDLE) && dc_good_line;
  wire bad_ref    = take && !chk.ref_legal;
  wire go         = take && chk.ref_legal;
  wire got        = (st == ST_GRANT) && bp_granted;
  wire grant_to   = (st == ST_GRANT) && !bp_granted && grant_t.expired;
  wire reply_ok   = (st == ST_REPLY) && bp_reply;
  wire reply_to   = (st == ST_REPLY) && !bp_reply && reply_t.expired;
  wire par_err    = reply_ok && !k_write && (remote_parity_lines != 2'h0);
  wire demand_rd  = !k_write && (k_kind == KIND_DEMAND);
  wire prefetch   = !k_write && (k_kind == KIND_PREFETCH);

  assign grant_t.run = (st == ST_GRANT);
  assign reply_t.run = (st == ST_REPLY);

  // next state of the reference sequencer
  always_comb
  begin
    next_st = st;
    case (st)
      ST_IDLE:  if (go) next_st = ST_GRANT;
      ST_GRANT: if (got) next_st = ST_REPLY;
                else if (grant_to) next_st = ST_IDLE;
      ST_REPLY: if (reply_ok || reply_to) next_st = ST_IDLE;
      default:  next_st = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // error events
  // ----------------------------------------------------------------
  wire mto_set    = reply_to && (demand_rd || k_write);
  wire par_set    = par_err && (demand_rd || prefetch);
  wire nognt_set  = grant_to && demand_rd;
  wire qb_event   = mto_set || par_set;
  wire qb_free    = !flag[FLAG_MTO] && !flag[FLAG_PAR];
  wire dma_event  = mem_error || dma_nem_error;
  wire dmae_free  = !flag[FLAG_MEM] && !flag[FLAG_DNEM];
  wire lost_set   = (qb_event && !qb_free) || (dma_event && !dmae_free);
  wire ro_write   = reg_strobe && reg_write && (chk.reg_hit[2] || chk.reg_hit[3]);
  wire pwr_fall   = pg_q && !power_good_line;

  // each report output ors its own independent event pulses
  wire next_mc    = bad_ref || (reply_to && demand_rd) || nognt_set
                    || (par_err && demand_rd) || ro_write;
  wire next_bexc  = (bad_ref && !ref_write) || (reply_to && demand_rd);
  wire next_hirq  = (bad_ref && ref_write) || (reply_to && k_write) || pwr_fall;
  wire next_dpint = (reply_to && k_write) || pwr_fall;
  wire next_inval = ((reply_to || grant_to || par_err) && demand_rd) || (par_err && prefetch);
  wire next_abort = reply_to || grant_to || par_err;
  wire next_done  = reply_ok && !par_err;

  // ----------------------------------------------------------------
  // error flags: hardware set beats any clear in the same cycle
  // ----------------------------------------------------------------
  wire [7:0] flag_set;
  wire [7:0] flag_w1c;
  wire       flag_wipe = io_reset || (!dc_good_line && cpu_halted);

  assign flag_set = {mto_set, 1'b0, par_set, mem_error, lost_set, nognt_set, 1'b0, dma_nem_error};
  assign flag_w1c = (reg_strobe && reg_write && chk.reg_hit[1] && reg_byte_en[0])
                    ? reg_wdata[7:0] : 8'h00;

  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_flag
      always_ff @(posedge clock)
      begin
        if (rst || !FLAG_IMPL[b])
          flag[b] <= FLAG_RESET[b];
        else if (flag_set[b])
          flag[b] <= 1'b1;
        else if (flag_w1c[b] || flag_wipe)
          flag[b] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // dma grant arbitration
  // ----------------------------------------------------------------
  assign ack_t.run    = (ar == AR_GRANT);
  assign settle_t.run = (ar == AR_SETTLE);

  // a silent withdraw: the ack timeout sets no flag and raises nothing
  always_comb
  begin
    next_ar = ar;
    case (ar)
      AR_IDLE:   if (dma_bus_req && dc_good_line) next_ar = AR_GRANT;
      AR_GRANT:  if (dma_ack) next_ar = AR_IDLE;
                 else if (ack_t.expired) next_ar = AR_SETTLE;
      AR_SETTLE: if (settle_t.expired) next_ar = AR_IDLE;
      default:   next_ar = AR_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // register read data
  // ----------------------------------------------------------------
  wire [31:0] ctl_val   = {16'h0000, pg_q, 15'h0000};
  wire [31:0] flag_val  = {24'h000000, flag};
  wire [31:0] bperr_val = {19'h00000, bperr};
  wire [31:0] dmae_val  = {12'h000, dmae};
  wire [31:0] next_rdata = chk.reg_hit[0] ? ctl_val :
                           chk.reg_hit[1] ? flag_val :
                           chk.reg_hit[2] ? bperr_val :
                           chk.reg_hit[3] ? dmae_val : 32'h0000_0000;

  // ----------------------------------------------------------------
  // state, captures and registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st <= ST_IDLE;
      ar <= AR_IDLE;
      pg_q <= 1'b1;
    end
    else
    begin
      st <= next_st;
      ar <= next_ar;
      pg_q <= power_good_line;
    end
  end

  // reference attributes held for the whole access
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      k_write <= 1'b0;
      k_kind  <= KIND_DEMAND;
      k_page  <= 13'h0000;
    end
    else if (go)
    begin
      k_write <= ref_write;
      k_kind  <= ref_kind;
      k_page  <= ref_addr[BPERR_HI:BPERR_LO];
    end
  end

  // first error address wins; later ones only mark the loss
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bperr <= 13'h0000;
      dmae  <= 20'h00000;
    end
    else
    begin
      if (qb_event && qb_free)
        bperr <= k_page;
      if (dma_event && dmae_free)
        dmae <= dma_map_addr[DMAE_HI:DMAE_LO];
    end
  end

  // reports are one-cycle pulses; vector and level hold until the next trap
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      machine_check            <= 1'b0;
      bus_exception            <= 1'b0;
      host_error_interrupt     <= 1'b0;
      dp_interrupt             <= 1'b0;
      dp_vector                <= 8'h00;
      interrupt_priority_level <= 5'h00;
      cache_invalidate         <= 1'b0;
      ref_abort                <= 1'b0;
      ref_done                 <= 1'b0;
      bp_request               <= 1'b0;
      dma_grant                <= 1'b0;
      reg_ack                  <= 1'b0;
      reg_rdata                <= 32'h0000_0000;
    end
    else
    begin
      machine_check        <= next_mc;
      bus_exception        <= next_bexc;
      host_error_interrupt <= next_hirq;
      dp_interrupt         <= next_dpint;
      if (next_dpint)
      begin
        dp_vector                <= pwr_fall ? VEC_POWERFAIL : VEC_WRITE_NEM;
        interrupt_priority_level <= LVL_WRITE_NEM;
      end
      cache_invalidate <= next_inval;
      ref_abort        <= next_abort || bad_ref;
      ref_done         <= next_done;
      bp_request       <= (next_st == ST_GRANT);
      dma_grant        <= (next_ar == AR_GRANT);
      reg_ack          <= reg_strobe;
      if (reg_strobe && !reg_write)
        reg_rdata <= next_rdata;
    end
  end

endmodule : backplane_bridge_error_handler

// ===== testbench/bridge_err_assertions.sv
// port-level checks on the bridge error handler, bound into its top module
`timescale 1ns/1ps

module bridge_err_assertions
  import bridge_err_pkg::*;
#(
  parameter int unsigned NO_GRANT_CYCLES = 50
)(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // register port
  input wire logic        reg_strobe,
  input wire logic        reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_ack,
  // reference and mastership
  input wire logic        ref_start,
  input wire logic        ref_write,
  input wire logic [1:0]  ref_size,
  input wire logic        ref_done,
  input wire logic        ref_abort,
  input wire logic        cache_invalidate,
  input wire logic        bp_request,
  input wire logic        dma_ack,
  input wire logic        dma_grant,
  input wire logic        power_good_line,
  input wire logic        dc_good_line,
  // reports
  input wire logic        machine_check,
  input wire logic        bus_exception,
  input wire logic        host_error_interrupt,
  input wire logic        dp_interrupt,
  input wire logic [7:0]  dp_vector,
  input wire logic [4:0]  interrupt_priority_level
);
  logic        busy;
  logic [15:0] g_len;
  logic [31:0] rq_len;
  wire         take     = ref_start && dc_good_line && !busy;
  wire         bad_size = ref_size != SIZE_WORD;

  // track the one reference in flight; a start while busy is ignored by the design
  always_ff @(posedge clock)
  begin
    busy   <= rst ? 1'b0 : (ref_done || ref_abort) ? 1'b0 : take ? 1'b1 : busy;
    g_len  <= (rst || !dma_grant) ? 16'h0000 : g_len + 16'h0001;
    rq_len <= (rst || !bp_request) ? 32'h0000_0000 : rq_len + 32'h0000_0001;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  reg_ack_a: assert property (reg_strobe |=> reg_ack) else $error("register access without ack");
  dmae_write_a: assert property (reg_strobe && reg_write && reg_addr == DMAE_ADDR |=> machine_check)
    else $error("write to dma error address gave no machine check");
  dmae_top_a: assert property (reg_strobe && !reg_write && reg_addr == DMAE_ADDR |=> reg_rdata[31:20] == 12'h000)
    else $error("dma error address upper bits not zero");
  bperr_top_a: assert property (reg_strobe && !reg_write && reg_addr == BPERR_ADDR |=> reg_rdata[31:13] == 19'h00000)
    else $error("backplane error address upper bits not zero");
  bad_size_a: assert property (take && bad_size |=> machine_check && ref_abort &&
    bus_exception != $past(ref_write) && host_error_interrupt == $past(ref_write)) else $error("bad size not reported");
  good_size_a: assert property (take && !bad_size |=> bp_request && !ref_abort)
    else $error("word reference did not request the bus");
  grant_wait_a: assert property (rq_len <= NO_GRANT_CYCLES + 1) else $error("bus request outlived grant timer");
  inval_abort_a: assert property (cache_invalidate |-> ref_abort) else $error("invalidate without abort");
  done_abort_a: assert property (!(ref_done && ref_abort)) else $error("done and abort together");
  ack_drop_a: assert property (dma_grant && dma_ack |=> !dma_grant) else $error("grant held after ack");
  grant_len_a: assert property (g_len <= 16'h0190) else $error("grant held past acknowledge timer");
  settle_a: assert property ($fell(dma_grant) && !$past(dma_ack) |-> !dma_grant [*8])
    else $error("grant reissued before chain settled");
  power_trap_a: assert property ($fell(power_good_line) |-> ##[1:2] dp_interrupt && host_error_interrupt &&
    dp_vector == VEC_POWERFAIL) else $error("power loss not trapped");
  trap_level_a: assert property (dp_interrupt |-> interrupt_priority_level == LVL_WRITE_NEM)
    else $error("wrong processor interrupt level");

  cover property (take && bad_size);
  cover property (dma_grant && dma_ack);
  cover property ($fell(power_good_line));
  cover property (cache_invalidate && !machine_check);
endmodule : bridge_err_assertions

bind backplane_bridge_error_handler bridge_err_assertions #(.NO_GRANT_CYCLES(NO_GRANT_CYCLES)) chk_u (.*);

// ===== testbench/backplane_partner.sv
// behavioural backplane slave, arbiter and dma master facing the bridge
`timescale 1ns/1ps

module backplane_partner
(
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // scenario controls
  input wire logic       grant_on,
  input wire logic       reply_on,
  input wire logic [1:0] par_val,
  input wire logic       ack_on,
  // bridge side
  input wire logic       bp_request,
  input wire logic       dma_grant,
  output logic           bp_granted,
  output logic           bp_reply,
  output logic [1:0]     remote_parity_lines,
  output logic           dma_ack
);
  logic       phase;
  logic [2:0] cnt;
  logic [1:0] churn;

  // lines carry the responder's parity report only with its reply, else they churn
  assign remote_parity_lines = bp_reply ? par_val : churn;

  initial {bp_granted, bp_reply, dma_ack, phase, cnt, churn} = '0;

  // grant one cycle after a request, reply four cycles later unless told to stay silent
  always @(posedge clock)
  begin
    bp_granted <= 1'b0;
    bp_reply   <= 1'b0;
    churn      <= churn + 2'h1;
    dma_ack    <= ack_on && dma_grant && !dma_ack;
    if (rst)
      phase <= 1'b0;
    else if (!phase && bp_request && grant_on && !bp_granted)
    begin
      bp_granted <= 1'b1;
      phase      <= 1'b1;
      cnt        <= 3'h0;
    end
    else if (phase)
    begin
      cnt      <= cnt + 3'h1;
      phase    <= cnt != 3'h3;
      bp_reply <= reply_on && cnt == 3'h3;
    end
  end
endmodule : backplane_partner

// ===== testbench/tb_backplane_bridge_error_handler.sv
// self-checking bench for the bridge error handler
`timescale 1ns/1ps

module tb_backplane_bridge_error_handler
  import bridge_err_pkg::*;
;
  logic        clock, rst, reg_strobe, reg_write, reg_ack, ref_start, ref_write, ref_done, ref_abort;
  logic        cache_invalidate, bp_request, bp_granted, bp_reply, dma_bus_req, dma_ack, dma_grant;
  logic        mem_error, dma_nem_error, power_good_line, machine_check, bus_exception, host_error_interrupt;
  logic        dp_interrupt, grant_on, reply_on, ack_on, clr_ev, dc_good_line, cpu_halted;
  logic [1:0]  ref_kind, ref_size, remote_parity_lines, par_val;
  logic [4:0]  interrupt_priority_level;
  logic [6:0]  ev;
  logic [7:0]  dp_vector;
  logic [21:0] ref_addr;
  logic [28:0] dma_map_addr;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, q;
  int          i, hi;
  int          miscompares = 0;
  int          cmp_count = 0;

  // grant timer shortened so a no-grant case costs fifty cycles
  backplane_bridge_error_handler #(.NO_GRANT_CYCLES(50)) dut_u (.*, .reg_size(SIZE_WORD), .reg_byte_en(4'hF),
    .io_reset(1'b0));
  backplane_partner partner_u (.*);

  always #12.5 clock = ~clock;

  // report pulses gathered per operation, cleared as each one starts
  always @(posedge clock) ev <= clr_ev ? 7'h00 : ev |
    {machine_check, bus_exception, host_error_interrupt, cache_invalidate, ref_done, ref_abort, dp_interrupt};

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bound(input logic ok);
    if (!ok)
    begin
      miscompares++;
      finish_test();
    end
  endtask : bound

  // drive at the rising edge, sample at the falling one so no race decides the outcome
  task automatic reg_op(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    reg_strobe <= 1'b1;
    reg_write  <= w;
    reg_addr   <= a;
    reg_wdata  <= d;
    clr_ev     <= 1'b1;
    @(posedge clock);
    reg_strobe <= 1'b0;
    clr_ev     <= 1'b0;
    n = 0;
    do @(negedge clock); while (reg_ack !== 1'b1 && ++n < 4);
    bound(n < 4);
    q = reg_rdata;
    @(negedge clock);
  endtask : reg_op

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    reg_op(1'b0, a, 32'h0000_0000);
    check(q, e);
  endtask : rd

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_op(1'b1, a, d);
  endtask : wr

  task automatic do_ref(input logic w, input logic [1:0] k, input logic [1:0] s, input logic [21:0] a,
                        input logic [6:0] e);
    int n;
    @(posedge clock);
    ref_start <= 1'b1;
    ref_write <= w;
    ref_kind  <= k;
    ref_size  <= s;
    ref_addr  <= a;
    clr_ev    <= 1'b1;
    @(posedge clock);
    ref_start <= 1'b0;
    clr_ev    <= 1'b0;
    n = 0;
    do @(negedge clock); while (ref_done !== 1'b1 && ref_abort !== 1'b1 && ++n < 1000);
    bound(n < 1000);
    @(negedge clock);
    check(ev, e);
  endtask : do_ref

  task automatic dma_err(input logic nem, input logic [28:0] a);
    @(posedge clock);
    mem_error     <= !nem;
    dma_nem_error <= nem;
    dma_map_addr  <= a;
    @(posedge clock);
    mem_error     <= 1'b0;
    dma_nem_error <= 1'b0;
  endtask : dma_err

  // one-cycle master request; hi ends as the grant length less one
  task automatic dma_req();
    @(posedge clock);
    dma_bus_req <= 1'b1;
    clr_ev      <= 1'b1;
    @(posedge clock);
    dma_bus_req <= 1'b0;
    clr_ev      <= 1'b0;
    hi = 0;
    do @(negedge clock); while (dma_grant !== 1'b1 && ++hi < 4);
    bound(hi < 4);
    hi = 0;
    do @(negedge clock); while (dma_grant === 1'b1 && ++hi < 600);
    bound(hi < 600);
  endtask : dma_req

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    {clock, reg_strobe, reg_write, ref_start, ref_write, dma_bus_req, mem_error, dma_nem_error, clr_ev} = '0;
    {rst, power_good_line, grant_on, reply_on, ack_on, dc_good_line} = '1;
    {ref_kind, ref_size, ref_addr, dma_map_addr, reg_addr, reg_wdata, par_val, cpu_halted} = '0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd(CTL_ADDR, 32'h0000_8000);
    rd(FLAG_ADDR, 32'h0000_0000);
    rd(BPERR_ADDR, 32'h0000_0000);
    rd(DMAE_ADDR, 32'h0000_0000);
    rd(32'h2008_0010, 32'h0000_0000);
    do_ref(1'b0, KIND_DEMAND, SIZE_WORD, 22'h00_0000, 7'h04);
    for (i = 0; i < 4; i++) do_ref(i[1], KIND_DEMAND, i[0] ? SIZE_HALF : SIZE_BYTE, 22'h0, i[1] ? 7'h52 : 7'h62);
    reply_on = 1'b0;
    do_ref(1'b0, KIND_DEMAND, SIZE_WORD, 22'h2A_5E00, 7'h6A);
    do_ref(1'b0, KIND_PREFETCH, SIZE_WORD, 22'h00_0200, 7'h02);
    do_ref(1'b0, KIND_INTACK, SIZE_WORD, 22'h00_0400, 7'h02);
    rd(FLAG_ADDR, 32'h0000_0080);
    rd(BPERR_ADDR, 32'h0000_152F);
    wr(FLAG_ADDR, 32'h0000_0000);
    rd(FLAG_ADDR, 32'h0000_0080);
    wr(FLAG_ADDR, 32'h0000_0080);
    rd(FLAG_ADDR, 32'h0000_0000);
    do_ref(1'b1, KIND_DEMAND, SIZE_WORD, 22'h3F_FE00, 7'h13);
    check(dp_vector, VEC_WRITE_NEM);
    check(interrupt_priority_level, LVL_WRITE_NEM);
    rd(BPERR_ADDR, 32'h0000_1FFF);
    wr(FLAG_ADDR, 32'h0000_00FF);
    reply_on = 1'b1;
    par_val = 2'h1;
    do_ref(1'b0, KIND_DEMAND, SIZE_WORD, 22'h00_1200, 7'h4A);
    par_val = 2'h2;
    do_ref(1'b0, KIND_PREFETCH, SIZE_WORD, 22'h00_0A00, 7'h0A);
    rd(FLAG_ADDR, 32'h0000_0028);
    rd(BPERR_ADDR, 32'h0000_0009);
    wr(FLAG_ADDR, 32'h0000_00FF);
    par_val = 2'h0;
    grant_on = 1'b0;
    do_ref(1'b0, KIND_DEMAND, SIZE_WORD, 22'h00_0000, 7'h4A);
    rd(FLAG_ADDR, 32'h0000_0004);
    grant_on = 1'b1;
    wr(FLAG_ADDR, 32'h0000_00FF);
    dma_err(1'b0, 29'h0ABC_DE00);
    dma_err(1'b1, 29'h1FFF_FE00);
    rd(DMAE_ADDR, 32'h0005_5E6F);
    rd(FLAG_ADDR, 32'h0000_0019);
    wr(FLAG_ADDR, 32'h0000_0019);
    dma_err(1'b1, 29'h1FFF_FE00);
    rd(DMAE_ADDR, 32'h000F_FFFF);
    wr(DMAE_ADDR, 32'hFFFF_FFFF);
    @(negedge clock);
    check(ev, 7'h40);
    rd(DMAE_ADDR, 32'h000F_FFFF);
    wr(FLAG_ADDR, 32'h0000_00FF);
    dma_req();
    check(hi < 4, 1'b1);
    ack_on = 1'b0;
    dma_req();
    check(hi >= 398 && hi <= 401, 1'b1);
    check(ev, 7'h00);
    rd(FLAG_ADDR, 32'h0000_0000);
    @(posedge clock);
    power_good_line <= 1'b0;
    clr_ev          <= 1'b1;
    @(posedge clock);
    clr_ev <= 1'b0;
    repeat (4) @(negedge clock);
    check(ev, 7'h11);
    check(dp_vector, VEC_POWERFAIL);
    rd(CTL_ADDR, 32'h0000_0000);
    dma_err(1'b0, 29'h0000_0000);
    rd(FLAG_ADDR, 32'h0000_0010);
    @(posedge clock);
    {dc_good_line, cpu_halted, dma_bus_req} <= 3'b011;
    repeat (4) @(negedge clock);
    check(dma_grant, 1'b0);
    rd(FLAG_ADDR, 32'h0000_0000);
    finish_test();
  end
endmodule : tb_backplane_bridge_error_handler
